/* File: shared/lmac_pkg.sv */
package lmac_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RXCODE   = 8'h28;
    localparam logic [7:0] IDX_THRESH   = 8'h29;
    localparam logic [7:0] IDX_MCTL_LOS = 8'h2C;
    localparam logic [7:0] IDX_MCTL_ERR = 8'h31;
    localparam logic [7:0] IDX_TERM     = 8'h32;
    localparam logic [7:0] IDX_IEN_LINE = 8'h33;
    localparam logic [7:0] IDX_IEN_ERR  = 8'h34;
    localparam logic [7:0] IDX_EDGE     = 8'h35;
    localparam logic [7:0] IDX_LSTAT    = 8'h36;
    localparam logic [7:0] IDX_IST_LINE = 8'h3A;
    localparam logic [7:0] IDX_IST_ERR  = 8'h3B;
    localparam logic [7:0] IDX_CNT_HI   = 8'h3C;
    localparam logic [7:0] IDX_CNT_LO   = 8'h3D;

    // Writable bits of each register
    localparam logic [7:0] M_RXCODE   = 8'h01;
    localparam logic [7:0] M_THRESH   = 8'h1F;
    localparam logic [7:0] M_MCTL_LOS = 8'h07;
    localparam logic [7:0] M_MCTL_ERR = 8'h5F;
    localparam logic [7:0] M_TERM     = 8'h3F;
    localparam logic [7:0] M_IEN_LINE = 8'h05;
    localparam logic [7:0] M_IEN_ERR  = 8'h77;
    localparam logic [7:0] M_EDGE     = 8'h05;

    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'h15;
    localparam logic [7:0] RST_TERM   = 8'h07;

    // Field positions
    localparam int B_AMI    = 0;
    localparam int B_CRIT   = 2;
    localparam int B_RAISE  = 1;
    localparam int B_TXONES = 0;
    localparam int B_VIOL   = 6;
    localparam int B_ZCRIT  = 4;
    localparam int B_ZEN_HI = 3;
    localparam int B_ZEN_LO = 2;
    localparam int B_RMODE  = 1;
    localparam int B_XFER   = 0;
    localparam int B_LOS    = 0;
    localparam int B_DF     = 2;
    localparam int B_DAC    = 6;
    localparam int B_TJA    = 5;
    localparam int B_RJA    = 4;
    localparam int B_EXZ    = 2;
    localparam int B_CV     = 1;
    localparam int B_CNTOV  = 0;
    localparam int B_TERMTOP = 2;
    localparam int B_TXT_HI = 4;
    localparam int B_TXT_LO = 3;

    // Counts in bit intervals; ZEN_ON is the count enable code, CNT_FULL the counter's full value
    localparam logic [10:0] LOS_RUN_T1   = 11'd175;
    localparam logic [10:0] LOS_RUN_I    = 11'd1544;
    localparam logic [6:0]  CLR_WIN_LAST = 7'd127;
    localparam logic [7:0]  CLR_MIN_ONES = 8'd16;
    localparam logic [6:0]  CLR_MAX_ZERO = 7'd100;
    localparam logic [6:0]  EXZ_AMI_ANSI = 7'd15;
    localparam logic [6:0]  EXZ_AMI_FCC  = 7'd80;
    localparam logic [6:0]  EXZ_B8ZS     = 7'd7;
    localparam logic [6:0]  ZRUN_MAX     = 7'd127;
    localparam logic [1:0]  ZEN_ON       = 2'b01;
    localparam logic [15:0] CNT_FULL     = 16'hFFFF;
    // Clear threshold sits 4 dB above declare; one code step is 2 dB
    localparam logic [4:0]  CLR_HYST     = 5'd2;

    typedef enum logic [1:0] {
        LS_OK   = 2'b01,
        LS_LOST = 2'b10
    } lmac_los_e;

    // Per-bit indications from the analog front end
    typedef struct packed {
        logic bitTick;
        logic levelBelow;
        logic levelAboveClear;
        logic rxMark;
        logic codeViol;
    } lmac_afe_s;

    // Other asynchronous status and event inputs
    typedef struct packed {
        logic driverFault;
        logic tmplOver;
        logic txFifoErr;
        logic rxFifoErr;
        logic oneSec;
    } lmac_ext_s;
endpackage

/* File: logic/lmac_line_maint.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
// Operation
// - Criterion 0: declare loss after 175 consecutive low-level bits.
// - Criterion 1: declare loss after 1544 consecutive low-level bits.
// - Clear needs level above clear point, 12.5% ones, run under 100 zeros per 128.
// - Declare threshold is Q; clear threshold is Q plus 4 dB.
// - Receive all-ones during loss when receive insertion enabled.
// - Transmit all-ones during receive loss when transmit insertion enabled.
// - Each rising edge of violation insert sends exactly one violation.
// - Zero criterion 0: error past 15 zeros AMI, past 7 B8ZS.
// - Zero criterion 1: error past 80 zeros AMI, B8ZS still 7.
// - Count zero errors in 16-bit counter only when enable field is 01.
// - Manual mode: transfer bit rising edge copies counter to result bytes.
// - Auto mode: counter copied to result bytes every second.
// - Transfer bit ignored in auto mode; software re-arms it through zero.
// - Receive codes 0-3 pick 75/120/100/110 ohm; top bit set bypasses.
// - A source reaches the interrupt pin only when its enable is set.
// - Edge select 0: flag set on rising status change only.
// - Edge select 1: flag set on either status change.
// - Driver failure status bit reads current transmit driver fault.
// - Loss status bit reads 1 while loss is declared.
// - Latched flags stay set until software writes one to clear.
// - Counter overflow sets a latched, maskable flag.
module lmac_line_maint
    import lmac_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire lmac_afe_s   afeIn,
    input  wire lmac_ext_s   extIn,
    input  wire logic        txDataIn,
    output logic             rxDataOut,
    output logic             txDataOut,
    output logic             txViolation,
    output logic [4:0]       declareThreshold,
    output logic [4:0]       clearThreshold,
    output logic [1:0]       rxTermSel,
    output logic             rxTermBypass,
    output logic [1:0]       txTermSel,
    output logic             irqOut
);
    lmac_afe_s   afeS1, afeS2;
    lmac_ext_s   extS1, extS2;
    logic        txS1, txS2, tickPrev, secPrev, dfPrev;
    logic [7:0]  rxCode, thresh, mctlLos, mctlErr, term, ienLine, ienErr, edgeSel;
    logic [7:0]  istLine, istErr, rdData;
    logic [7:0]  next_istLine, next_istErr;
    lmac_los_e   losState;
    logic        losS, losPrev;
    logic [10:0] belowRun, losLimit;
    logic [6:0]  zeroRun, winCnt, exzLimit;
    logic [7:0]  onesCnt;
    logic        aboveAll, longRun;
    logic [15:0] zeroCnt, resultCnt;
    logic        violPrev, violPend, xferPrev, exzEvt, cntOvf;
    logic        bitEdge, secEdge, winLast, clearOk, wrEn, aligned, hit;
    logic [6:0]  zeroNext;

    // Either-edge or rising-edge detect, shared by loss and driver fault
    function automatic logic edgeHit(input logic cur, input logic prev, input logic both);
        edgeHit = both ? (cur ^ prev) : (cur & ~prev);
    endfunction

    // Every front-end, status and transmit data input crosses two flops before any logic reads it; the APB inputs are used directly
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            afeS1 <= '0;
            afeS2 <= '0;
            extS1 <= '0;
            extS2 <= '0;
            txS1  <= 1'b0;
            txS2  <= 1'b0;
        end else begin
            afeS1 <= afeIn;
            afeS2 <= afeS1;
            extS1 <= extIn;
            extS2 <= extS1;
            txS1  <= txDataIn;
            txS2  <= txS1;
        end
    end

    // Edge history taken from the second stage, and from the loss state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickPrev <= 1'b0;
            secPrev  <= 1'b0;
            dfPrev   <= 1'b0;
            losPrev  <= 1'b0;
        end else begin
            tickPrev <= afeS2.bitTick;
            secPrev  <= extS2.oneSec;
            dfPrev   <= extS2.driverFault;
            losPrev  <= losS;
        end
    end

    assign bitEdge = afeS2.bitTick & ~tickPrev;
    assign secEdge = extS2.oneSec & ~secPrev;
    assign losS    = (losState == LS_LOST);

    // Bus decode: access phase waits one cycle so read data is registered
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'd0);
    assign wrEn    = psel & penable & pready & pwrite & aligned;

    always_comb begin
        hit    = aligned;
        rdData = 8'h00;
        unique case (paddr[9:2])
            IDX_RXCODE:   rdData = rxCode;
            IDX_THRESH:   rdData = thresh;
            IDX_MCTL_LOS: rdData = mctlLos;
            IDX_MCTL_ERR: rdData = mctlErr;
            IDX_TERM:     rdData = term;
            IDX_IEN_LINE: rdData = ienLine;
            IDX_IEN_ERR:  rdData = ienErr;
            IDX_EDGE:     rdData = edgeSel;
            IDX_LSTAT: begin
                rdData[B_DF]  = extS2.driverFault;
                rdData[B_LOS] = losS;
            end
            IDX_IST_LINE: rdData = istLine;
            IDX_IST_ERR:  rdData = istErr;
            IDX_CNT_HI:   rdData = resultCnt[15:8];
            IDX_CNT_LO:   rdData = resultCnt[7:0];
            default:      hit = 1'b0;
        endcase
    end

    // Answer: pready rises one cycle into the access phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            prdata  <= {24'h00_0000, (pwrite ? 8'h00 : rdData)};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCode  <= RST_ZERO;
            thresh  <= RST_THRESH;
            mctlLos <= RST_ZERO;
            mctlErr <= RST_ZERO;
            term    <= RST_TERM;
            ienLine <= RST_ZERO;
            ienErr  <= RST_ZERO;
            edgeSel <= RST_ZERO;
        end else if (wrEn) begin
            unique case (paddr[9:2])
                IDX_RXCODE:   rxCode  <= pwdata[7:0] & M_RXCODE;
                IDX_THRESH:   thresh  <= pwdata[7:0] & M_THRESH;
                IDX_MCTL_LOS: mctlLos <= pwdata[7:0] & M_MCTL_LOS;
                IDX_MCTL_ERR: mctlErr <= pwdata[7:0] & M_MCTL_ERR;
                IDX_TERM:     term    <= pwdata[7:0] & M_TERM;
                IDX_IEN_LINE: ienLine <= pwdata[7:0] & M_IEN_LINE;
                IDX_IEN_ERR:  ienErr  <= pwdata[7:0] & M_IEN_ERR;
                IDX_EDGE:     edgeSel <= pwdata[7:0] & M_EDGE;
                default:      ;
            endcase
        end
    end

    // Front-end thresholds and termination decode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            declareThreshold <= RST_THRESH[4:0];
            clearThreshold   <= RST_THRESH[4:0] - CLR_HYST;
            rxTermSel        <= RST_TERM[1:0];
            rxTermBypass     <= RST_TERM[B_TERMTOP];
            txTermSel        <= 2'b00;
        end else begin
            declareThreshold <= thresh[4:0];
            clearThreshold   <= (thresh[4:0] > CLR_HYST) ? thresh[4:0] - CLR_HYST
                                                         : 5'd0;
            rxTermSel        <= term[1:0];
            rxTermBypass     <= term[B_TERMTOP];
            txTermSel        <= term[B_TXT_HI:B_TXT_LO];
        end
    end

    assign losLimit = mctlLos[B_CRIT] ? LOS_RUN_I : LOS_RUN_T1;
    assign winLast  = bitEdge && (winCnt == CLR_WIN_LAST);
    assign clearOk  = aboveAll && afeS2.levelAboveClear && !longRun
                      && (zeroNext < CLR_MAX_ZERO)
                      && (onesCnt + {7'd0, afeS2.rxMark} >= CLR_MIN_ONES);

    // Run of bits below the declare threshold
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            belowRun <= 11'd0;
        end else if (bitEdge) begin
            if (!afeS2.levelBelow || losS)
                belowRun <= 11'd0;
            else if (belowRun != LOS_RUN_I)
                belowRun <= belowRun + 11'd1;
        end
    end

    // 128-bit clearing window; judged only at its last bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            winCnt   <= 7'd0;
            onesCnt  <= 8'd0;
            aboveAll <= 1'b1;
            longRun  <= 1'b0;
        end else if (bitEdge) begin
            winCnt <= winCnt + 7'd1;
            if (winLast) begin
                onesCnt  <= 8'd0;
                aboveAll <= 1'b1;
                longRun  <= 1'b0;
            end else begin
                onesCnt  <= onesCnt + {7'd0, afeS2.rxMark};
                aboveAll <= aboveAll & afeS2.levelAboveClear;
                longRun  <= longRun | (zeroNext >= CLR_MAX_ZERO);
            end
        end
    end

    // Loss state machine
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            losState <= LS_OK;
        end else begin
            unique case (losState)
                LS_OK:
                    if (bitEdge && afeS2.levelBelow && belowRun == losLimit - 11'd1)
                        losState <= LS_LOST;
                LS_LOST:
                    if (winLast && clearOk)
                        losState <= LS_OK;
                default: losState <= LS_OK;
            endcase
        end
    end

    // Data paths; all-ones override follows loss within one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxDataOut <= 1'b0;
            txDataOut <= 1'b0;
        end else begin
            rxDataOut <= (losS && mctlLos[B_RAISE]) ? 1'b1 : afeS2.rxMark;
            txDataOut <= (losS && mctlLos[B_TXONES]) ? 1'b1 : txS2;
        end
    end

    // One violation per rising edge, sent on the next bit interval
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            violPrev    <= 1'b0;
            violPend    <= 1'b0;
            txViolation <= 1'b0;
        end else begin
            violPrev <= mctlErr[B_VIOL];
            if (mctlErr[B_VIOL] && !violPrev)
                violPend <= 1'b1;
            else if (bitEdge)
                violPend <= 1'b0;
            if (bitEdge)
                txViolation <= violPend;
        end
    end

    // Zero run limit by line code and criterion
    always_comb begin
        if (!rxCode[B_AMI])
            exzLimit = EXZ_B8ZS;
        else
            exzLimit = mctlErr[B_ZCRIT] ? EXZ_AMI_FCC : EXZ_AMI_ANSI;
    end

    assign zeroNext = afeS2.rxMark ? 7'd0 :
                      (zeroRun == ZRUN_MAX) ? ZRUN_MAX : zeroRun + 7'd1;
    assign exzEvt   = bitEdge && !afeS2.rxMark && (zeroNext == exzLimit + 7'd1);
    assign cntOvf   = exzEvt && (mctlErr[B_ZEN_HI:B_ZEN_LO] == ZEN_ON) && zeroCnt == CNT_FULL;

    // Zero run tracker
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            zeroRun <= 7'd0;
        else if (bitEdge)
            zeroRun <= zeroNext;
    end

    // Error counter and report transfer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zeroCnt   <= 16'h0000;
            resultCnt <= 16'h0000;
            xferPrev  <= 1'b0;
        end else begin
            xferPrev <= mctlErr[B_XFER];
            if (exzEvt && mctlErr[B_ZEN_HI:B_ZEN_LO] == ZEN_ON)
                zeroCnt <= zeroCnt + 16'h0001;
            if (!mctlErr[B_RMODE] && mctlErr[B_XFER] && !xferPrev)
                resultCnt <= zeroCnt;
            else if (mctlErr[B_RMODE] && secEdge)
                resultCnt <= zeroCnt;
        end
    end

    // Sticky flags: a set in the clearing cycle wins over the clear
    always_comb begin
        next_istLine = istLine;
        next_istErr  = istErr;
        if (wrEn && paddr[9:2] == IDX_IST_LINE)
            next_istLine = istLine & ~pwdata[7:0];
        if (wrEn && paddr[9:2] == IDX_IST_ERR)
            next_istErr = istErr & ~pwdata[7:0];
        if (edgeHit(losS, losPrev, edgeSel[B_LOS]))
            next_istLine[B_LOS] = 1'b1;
        if (edgeHit(extS2.driverFault, dfPrev, edgeSel[B_DF]))
            next_istLine[B_DF] = 1'b1;
        if (extS2.tmplOver)
            next_istErr[B_DAC] = 1'b1;
        if (extS2.txFifoErr)
            next_istErr[B_TJA] = 1'b1;
        if (extS2.rxFifoErr)
            next_istErr[B_RJA] = 1'b1;
        if (exzEvt)
            next_istErr[B_EXZ] = 1'b1;
        if (bitEdge && afeS2.codeViol)
            next_istErr[B_CV] = 1'b1;
        if (cntOvf)
            next_istErr[B_CNTOV] = 1'b1;
    end

    // Flag registers and masked interrupt pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            istLine <= RST_ZERO;
            istErr  <= RST_ZERO;
            irqOut  <= 1'b0;
        end else begin
            istLine <= next_istLine;
            istErr  <= next_istErr;
            irqOut  <= |{istLine & ienLine, istErr & ienErr};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_lowRunEnds(logic [10:0] lim);
        bitEdge && afeS2.levelBelow && losState == LS_OK && belowRun == lim - 11'd1;
    endsequence
    property p_declare_short;
        s_lowRunEnds(LOS_RUN_T1) and !mctlLos[B_CRIT] |=> losS && !losPrev;
    endproperty
    a_declare_short: assert property (p_declare_short) else $error("short loss not declared");
    property p_declare_long;
        $rose(losS) && mctlLos[B_CRIT] |-> $past(belowRun) == LOS_RUN_I - 11'd1;
    endproperty
    a_declare_long: assert property (p_declare_long) else $error("long loss early");
    property p_clear;
        $fell(losS) |-> $past(winLast && aboveAll && !longRun);
    endproperty
    a_clear: assert property (p_clear) else $error("loss cleared off window");
    property p_hyst;
        $stable(thresh) && thresh[4:0] > CLR_HYST |=> declareThreshold - clearThreshold == CLR_HYST;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis wrong");
    property p_rx_ones;
        losS && mctlLos[B_RAISE] |=> rxDataOut;
    endproperty
    a_rx_ones: assert property (p_rx_ones) else $error("receive not forced");
    property p_tx_ones;
        losS && mctlLos[B_TXONES] |=> txDataOut;
    endproperty
    a_tx_ones: assert property (p_tx_ones) else $error("transmit not forced");
    sequence s_violArm;
        $rose(violPend);
    endsequence
    property p_viol;
        $rose(txViolation) |-> $past(violPend) and $past(bitEdge);
    endproperty
    a_viol: assert property (p_viol) else $error("stray violation");
    property p_viol_once;
        mctlErr[B_VIOL] && violPrev && !violPend |=> !violPend;
    endproperty
    a_viol_once: assert property (p_viol_once) else $error("held bit re-armed");
    property p_count_gate;
        mctlErr[B_ZEN_HI:B_ZEN_LO] != ZEN_ON |=> $stable(zeroCnt);
    endproperty
    a_count_gate: assert property (p_count_gate) else $error("counted while off");
    property p_auto_ignores;
        mctlErr[B_RMODE] && !secEdge |=> $stable(resultCnt);
    endproperty
    a_auto_ignores: assert property (p_auto_ignores) else $error("auto copied early");
    property p_w1c_set_wins;
        exzEvt |=> istErr[B_EXZ] ##1 (istErr[B_EXZ] || $past(wrEn));
    endproperty
    a_w1c_set_wins: assert property (p_w1c_set_wins) else $error("event lost");
    property p_irq;
        |{istLine & ienLine, istErr & ienErr} |=> irqOut;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
    property p_irq_mask;
        !(|{istLine & ienLine, istErr & ienErr}) |=> !irqOut;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked source on pin");
endmodule

/* File: tb/tb_lmac_line_maint.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_lmac_line_maint
    import lmac_pkg::*;
;
    typedef struct packed {logic rd; logic [7:0] d; logic err;} lmac_exp_s;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, rxDataOut, txDataOut, txViolation, rxTermBypass, irqOut;
    logic [4:0]  declareThreshold, clearThreshold;
    logic [1:0]  rxTermSel, txTermSel;
    lmac_afe_s   afe      = '0;
    lmac_ext_s   ext      = '0;
    logic        txDataIn = 1'b0;
    logic        m, t;
    int          miscompares, comparisons, i;
    int          seed = 89;
    lmac_exp_s   e;
    lmac_exp_s   expQ[$];

    lmac_line_maint DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .afeIn(afe), .extIn(ext), .txDataIn(txDataIn),
        .rxDataOut(rxDataOut), .txDataOut(txDataOut), .txViolation(txViolation),
        .declareThreshold(declareThreshold), .clearThreshold(clearThreshold),
        .rxTermSel(rxTermSel), .rxTermBypass(rxTermBypass), .txTermSel(txTermSel),
        .irqOut(irqOut));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    task wrap_up;
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; expectation noted first, answer judged by the monitor
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
             input logic [7:0] ex, input logic er);
        int n;
        expQ.push_back(lmac_exp_s'{!wr, ex, er});
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= {22'h0, idx, 2'b00}; pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin miscompares++; wrap_up(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // One bit interval; long enough for the synchronisers to settle before return
    task tick(input logic mark, input logic low);
        @(posedge ref_clk);
        afe.bitTick <= 1'b1; afe.rxMark <= mark;
        afe.levelBelow <= low; afe.levelAboveClear <= !low;
        repeat (2) @(posedge ref_clk);
        afe.bitTick <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Monitor: oldest note is compared whenever the slave answers
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            if (e.rd) `CHK("prdata", {24'h0, e.d}, prdata);
            `CHK("pslverr", e.err, pslverr);
        end
    end

    // Main sequence
    initial begin
        waitc(20);
        rst_n <= 1'b1;
        waitc(1);
        `CHK("declThr", 5'h15, declareThreshold);
        `CHK("clrThr", 5'h13, clearThreshold);
        `CHK("bypass", 1'b1, rxTermBypass);
        apb(1'b0, IDX_TERM, 8'h00, RST_TERM, 1'b0);
        apb(1'b1, 8'h30, 8'hFF, 8'h00, 1'b1);
        apb(1'b1, IDX_LSTAT, 8'hFF, 8'h00, 1'b0);
        apb(1'b1, IDX_THRESH, 8'h08, 8'h00, 1'b0);
        waitc(2);
        `CHK("clrThr", 5'h06, clearThreshold);
        // Every receive termination code, bypass on the top bit
        for (i = 0; i < 5; i++) begin
            apb(1'b1, IDX_TERM, {3'h0, i[1:0], i[2:0]}, 8'h00, 1'b0);
            waitc(2);
            `CHK("rxTerm", i[1:0], rxTermSel);
            `CHK("rxByp", i[2], rxTermBypass);
            `CHK("txTerm", i[1:0], txTermSel);
        end
        // Loss declare at exactly 175 low bits, fault status alongside
        ext.driverFault <= 1'b1;
        repeat (174) tick(1'b0, 1'b1);
        apb(1'b0, IDX_LSTAT, 8'h00, 8'h04, 1'b0);
        tick(1'b0, 1'b1);
        apb(1'b0, IDX_LSTAT, 8'h00, 8'h05, 1'b0);
        apb(1'b0, IDX_IST_LINE, 8'h00, 8'h05, 1'b0);
        `CHK("irqMasked", 1'b0, irqOut);
        apb(1'b1, IDX_IEN_LINE, 8'h01, 8'h00, 1'b0);
        waitc(2);
        `CHK("irqOn", 1'b1, irqOut);
        apb(1'b1, IDX_IST_LINE, 8'h05, 8'h00, 1'b0);
        waitc(2);
        `CHK("irqOff", 1'b0, irqOut);
        apb(1'b0, IDX_IST_LINE, 8'h00, 8'h00, 1'b0);
        // All-ones on both paths during loss
        apb(1'b1, IDX_MCTL_LOS, 8'h03, 8'h00, 1'b0);
        tick(1'b0, 1'b1);
        `CHK("rxOnes", 1'b1, rxDataOut);
        `CHK("txOnes", 1'b1, txDataOut);
        // Clear on healthy signal; falling change flags with both-edge select
        apb(1'b1, IDX_EDGE, 8'h01, 8'h00, 1'b0);
        repeat (256) tick(1'b1, 1'b0);
        apb(1'b0, IDX_LSTAT, 8'h00, 8'h04, 1'b0);
        apb(1'b0, IDX_IST_LINE, 8'h00, 8'h01, 1'b0);
        `CHK("irqFall", 1'b1, irqOut);
        // Random data passes unchanged once loss has cleared
        repeat (8) begin
            m = $random(seed);
            t = $random(seed);
            txDataIn <= t;
            tick(m, 1'b0);
            `CHK("rxPass", m, rxDataOut);
            `CHK("txPass", t, txDataOut);
        end
        // Zero runs under the default line code: 7 is fine, 8 is an error
        apb(1'b1, IDX_MCTL_ERR, 8'h04, 8'h00, 1'b0);
        apb(1'b1, IDX_IST_ERR, 8'h77, 8'h00, 1'b0);
        tick(1'b1, 1'b0);
        repeat (7) tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        repeat (8) tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        apb(1'b1, IDX_MCTL_ERR, 8'h05, 8'h00, 1'b0);
        apb(1'b0, IDX_CNT_LO, 8'h00, 8'h01, 1'b0);
        apb(1'b0, IDX_CNT_HI, 8'h00, 8'h00, 1'b0);
        apb(1'b0, IDX_IST_ERR, 8'h00, 8'h04, 1'b0);
        // Auto mode ignores the transfer bit and copies on the one-second tick
        apb(1'b1, IDX_MCTL_ERR, 8'h06, 8'h00, 1'b0);
        repeat (8) tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        apb(1'b1, IDX_MCTL_ERR, 8'h07, 8'h00, 1'b0);
        apb(1'b0, IDX_CNT_LO, 8'h00, 8'h01, 1'b0);
        ext.oneSec <= 1'b1;
        waitc(4);
        ext.oneSec <= 1'b0;
        waitc(4);
        apb(1'b0, IDX_CNT_LO, 8'h00, 8'h02, 1'b0);
        // Long criterion: 1543 low bits keep the line up, the 1544th declares
        apb(1'b1, IDX_MCTL_LOS, 8'h04, 8'h00, 1'b0);
        repeat (1543) tick(1'b0, 1'b1);
        apb(1'b0, IDX_LSTAT, 8'h00, 8'h04, 1'b0);
        tick(1'b0, 1'b1);
        apb(1'b0, IDX_LSTAT, 8'h00, 8'h05, 1'b0);
        // Zero criterion 1 under AMI: 80 zeros pass, the 81st flags
        apb(1'b1, IDX_RXCODE, 8'h01, 8'h00, 1'b0);
        apb(1'b1, IDX_MCTL_ERR, 8'h10, 8'h00, 1'b0);
        tick(1'b1, 1'b0);
        apb(1'b1, IDX_IST_ERR, 8'h77, 8'h00, 1'b0);
        repeat (80) tick(1'b0, 1'b0);
        apb(1'b0, IDX_IST_ERR, 8'h00, 8'h00, 1'b0);
        tick(1'b0, 1'b0);
        apb(1'b0, IDX_IST_ERR, 8'h00, 8'h04, 1'b0);
        // One violation per rising edge of the insert bit
        apb(1'b1, IDX_MCTL_ERR, 8'h40, 8'h00, 1'b0);
        tick(1'b1, 1'b0);
        `CHK("violOn", 1'b1, txViolation);
        tick(1'b1, 1'b0);
        `CHK("violOnce", 1'b0, txViolation);
        // Software re-arms through zero for a further violation
        apb(1'b1, IDX_MCTL_ERR, 8'h00, 8'h00, 1'b0);
        apb(1'b1, IDX_MCTL_ERR, 8'h40, 8'h00, 1'b0);
        tick(1'b1, 1'b0);
        `CHK("violAgain", 1'b1, txViolation);
        waitc(4);
        wrap_up();
    end
endmodule
